// >>> src/tpc_pkg.sv
/*
 * tpc_pkg: constants and carriers for the temperature profile control
 * register. Assumes a byte-wide register port behind a serial front end.
 */
package tpc_pkg;
    localparam logic [7:0] TPC_ADDR = 8'h0C;
    localparam logic [7:0] TPC_RESET_VALUE = 8'h75;
    localparam int COOL_MSB = 7;
    localparam int COOL_LSB = 6;
    localparam int WARM_MSB = 5;
    localparam int WARM_LSB = 4;
    localparam int LOWT_MSB = 3;
    localparam int LOWT_LSB = 2;
    localparam int UPT_MSB = 1;
    localparam int UPT_LSB = 0;
    localparam logic [1:0] SCALE_NONE = 2'h0;
    localparam logic [1:0] SCALE_FULL = 2'h3;
    // threshold ratios in hundredths of a percent of the reference
    localparam logic [13:0] LOWT_RATIO_0 = 14'h1BA3; // 70.75 percent
    localparam logic [13:0] LOWT_RATIO_1 = 14'h1AA9; // 68.25 percent
    localparam logic [13:0] LOWT_RATIO_2 = 14'h197D; // 65.25 percent
    localparam logic [13:0] LOWT_RATIO_3 = 14'h1851; // 62.25 percent
    localparam logic [13:0] UPT_RATIO_0 = 14'h12D9; // 48.25 percent
    localparam logic [13:0] UPT_RATIO_1 = 14'h117B; // 44.75 percent
    localparam logic [13:0] UPT_RATIO_2 = 14'h0FEB; // 40.75 percent
    localparam logic [13:0] UPT_RATIO_3 = 14'h0EBF; // 37.75 percent
    // current scale in percent of the fast charge setting
    localparam logic [6:0] PCT_0 = 7'h00; // no charge
    localparam logic [6:0] PCT_1 = 7'h14; // 20 percent
    localparam logic [6:0] PCT_2 = 7'h32; // 50 percent
    localparam logic [6:0] PCT_3 = 7'h64; // full current

    typedef enum logic [1:0] {
        TPC_NORMAL,
        TPC_RANGE_COOL,
        TPC_RANGE_WARM
    } tpc_range_t;

    typedef struct packed {
        logic [6:0] charge_pct;
        logic [13:0] lower_ratio;
        logic [13:0] upper_ratio;
        logic timer_double;
    } tpc_ctrl_t;
endpackage : tpc_pkg

// >>> src/tpc_reg.sv
/*
 * tpc_reg: temperature profile control register with decoded outputs.
 * Assumes a serial front end delivers one-cycle write strobes and
 * samples read data combinationally from rd_data.
 */
`timescale 1ns/1ps
// Operation
// - an eight-bit read/write register at offset 0x0C resets to 0x75.
// - in the cool range the charge current is scaled by bits 7:6.
// - in the warm range the charge current is scaled by bits 5:4.
// - a full-current code in a range keeps the safety timer undoubled.
// - bits 3:2 select the lower temperature threshold ratio.
// - bits 1:0 select the upper temperature threshold ratio.
// - a register-reset request restores defaults and resets the timer.
// - watchdog expiry restores defaults and enters default mode.
module tpc_reg (
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic reg_rst_req,
    input wire logic wdog_expire,
    input wire tpc_pkg::tpc_range_t temp_range,
    output tpc_pkg::tpc_ctrl_t ctrl,
    output logic safety_timer_rst,
    output logic wdog_fault
);
    import tpc_pkg::*;

    typedef struct packed {
        logic [7:0] cfg;
        tpc_ctrl_t ctrl;
        logic tmr_rst;
        logic fault;
    } tpc_state_t;

    tpc_state_t state_reg;
    tpc_state_t state_next;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic [6:0] tpc_pct(input logic [1:0] code);
        case (code)
            2'h0: tpc_pct = PCT_0;
            2'h1: tpc_pct = PCT_1;
            2'h2: tpc_pct = PCT_2;
            default: tpc_pct = PCT_3;
        endcase
    endfunction : tpc_pct

    function automatic tpc_ctrl_t tpc_decode(input logic [7:0] c,
                                             input tpc_range_t r);
        logic [1:0] sc;
        sc = SCALE_FULL;
        tpc_decode = '0;
        if (r == TPC_RANGE_COOL) begin
            sc = c[COOL_MSB:COOL_LSB];
        end else if (r == TPC_RANGE_WARM) begin
            sc = c[WARM_MSB:WARM_LSB];
        end
        tpc_decode.charge_pct = tpc_pct(sc);
        // timer doubles only for reduced, nonzero current in a range
        tpc_decode.timer_double = (r != TPC_NORMAL) && (sc != SCALE_FULL)
            && (sc != SCALE_NONE);
        case (c[LOWT_MSB:LOWT_LSB])
            2'h0: tpc_decode.lower_ratio = LOWT_RATIO_0;
            2'h1: tpc_decode.lower_ratio = LOWT_RATIO_1;
            2'h2: tpc_decode.lower_ratio = LOWT_RATIO_2;
            default: tpc_decode.lower_ratio = LOWT_RATIO_3;
        endcase
        case (c[UPT_MSB:UPT_LSB])
            2'h0: tpc_decode.upper_ratio = UPT_RATIO_0;
            2'h1: tpc_decode.upper_ratio = UPT_RATIO_1;
            2'h2: tpc_decode.upper_ratio = UPT_RATIO_2;
            default: tpc_decode.upper_ratio = UPT_RATIO_3;
        endcase
    endfunction : tpc_decode

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.tmr_rst = 1'b0;
        if (reg_rst_req) begin
            state_next.cfg = TPC_RESET_VALUE;
            state_next.tmr_rst = 1'b1;
        end else if (wdog_expire) begin
            state_next.cfg = TPC_RESET_VALUE;
        end else if (wr_en && addr == TPC_ADDR) begin
            state_next.cfg = wr_data;
        end
        // fault set wins; a later host write returns to host mode
        if (wdog_expire) begin
            state_next.fault = 1'b1;
        end else if (wr_en) begin
            state_next.fault = 1'b0;
        end
        state_next.ctrl = tpc_decode(state_next.cfg, temp_range);
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg.cfg <= TPC_RESET_VALUE;
            // outputs show the decoded default while held in reset
            state_reg.ctrl <= tpc_decode(TPC_RESET_VALUE, TPC_NORMAL);
            state_reg.tmr_rst <= 1'b0;
            state_reg.fault <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign rd_data = state_reg.cfg;
    assign ctrl = state_reg.ctrl;
    assign safety_timer_rst = state_reg.tmr_rst;
    assign wdog_fault = state_reg.fault;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rst_req;
        reg_rst_req;
    endsequence

    sequence s_default_seen;
        rd_data == TPC_RESET_VALUE && safety_timer_rst;
    endsequence

    AST_RESET_VALUE: assert property (@(posedge clk)
        $fell(srst) |-> rd_data == TPC_RESET_VALUE)
        else $error("register not at reset value");
    AST_WRITE: assert property (@(posedge clk) disable iff (srst)
        wr_en && addr == TPC_ADDR && !reg_rst_req && !wdog_expire
        |=> rd_data == $past(wr_data))
        else $error("write not stored");
    AST_COOL: assert property (@(posedge clk) disable iff (srst)
        temp_range == TPC_RANGE_COOL && !reg_rst_req && !wdog_expire
        && !wr_en |=> ctrl.charge_pct == tpc_pct(rd_data[COOL_MSB:COOL_LSB]))
        else $error("cool scale wrong");
    AST_WARM: assert property (@(posedge clk) disable iff (srst)
        temp_range == TPC_RANGE_WARM && !reg_rst_req && !wdog_expire
        && !wr_en |=> ctrl.charge_pct == tpc_pct(rd_data[WARM_MSB:WARM_LSB]))
        else $error("warm scale wrong");
    AST_NO_DOUBLE: assert property (@(posedge clk) disable iff (srst)
        ctrl.charge_pct == PCT_3 |-> !ctrl.timer_double)
        else $error("timer doubled at full current");
    AST_LOWT: assert property (@(posedge clk) disable iff (srst)
        rd_data[LOWT_MSB:LOWT_LSB] == 2'h1
        |-> ctrl.lower_ratio == LOWT_RATIO_1)
        else $error("lower threshold wrong");
    AST_UPT: assert property (@(posedge clk) disable iff (srst)
        rd_data[UPT_MSB:UPT_LSB] == 2'h1
        |-> ctrl.upper_ratio == UPT_RATIO_1)
        else $error("upper threshold wrong");
    AST_REG_RST: assert property (@(posedge clk) disable iff (srst)
        s_rst_req |=> s_default_seen)
        else $error("register reset not applied");
    AST_WDOG: assert property (@(posedge clk) disable iff (srst)
        wdog_expire |=> wdog_fault && rd_data == TPC_RESET_VALUE)
        else $error("watchdog expiry not handled");

    ////////////////////////////////////////////////////////////////////
    // range decode per code; ctrl follows the range seen one edge back
    sequence s_cool_code(logic [1:0] code);
        !$past(srst) && $past(temp_range) == TPC_RANGE_COOL
        && rd_data[COOL_MSB:COOL_LSB] == code;
    endsequence

    sequence s_warm_code(logic [1:0] code);
        !$past(srst) && $past(temp_range) == TPC_RANGE_WARM
        && rd_data[WARM_MSB:WARM_LSB] == code;
    endsequence

    AST_COOL_NONE: assert property (@(posedge clk) disable iff (srst)
        s_cool_code(2'h0) |-> ctrl.charge_pct == PCT_0 && !ctrl.timer_double)
        else $error("cool no-charge code wrong");
    AST_COOL_LOW: assert property (@(posedge clk) disable iff (srst)
        s_cool_code(2'h1) |-> ctrl.charge_pct == PCT_1 && ctrl.timer_double)
        else $error("cool low code wrong");
    AST_COOL_HALF: assert property (@(posedge clk) disable iff (srst)
        s_cool_code(2'h2) |-> ctrl.charge_pct == PCT_2 && ctrl.timer_double)
        else $error("cool half code wrong");
    AST_COOL_FULL: assert property (@(posedge clk) disable iff (srst)
        s_cool_code(2'h3) |-> ctrl.charge_pct == PCT_3 && !ctrl.timer_double)
        else $error("cool full code wrong");
    AST_WARM_NONE: assert property (@(posedge clk) disable iff (srst)
        s_warm_code(2'h0) |-> ctrl.charge_pct == PCT_0 && !ctrl.timer_double)
        else $error("warm no-charge code wrong");
    AST_WARM_LOW: assert property (@(posedge clk) disable iff (srst)
        s_warm_code(2'h1) |-> ctrl.charge_pct == PCT_1 && ctrl.timer_double)
        else $error("warm low code wrong");
    AST_WARM_HALF: assert property (@(posedge clk) disable iff (srst)
        s_warm_code(2'h2) |-> ctrl.charge_pct == PCT_2 && ctrl.timer_double)
        else $error("warm half code wrong");
    AST_WARM_FULL: assert property (@(posedge clk) disable iff (srst)
        s_warm_code(2'h3) |-> ctrl.charge_pct == PCT_3 && !ctrl.timer_double)
        else $error("warm full code wrong");

    // outside both ranges the current is never scaled
    AST_NO_RANGE: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) && $past(temp_range) == TPC_NORMAL
        |-> ctrl.charge_pct == PCT_3 && !ctrl.timer_double)
        else $error("scaling outside a range");

    ////////////////////////////////////////////////////////////////////
    // threshold decode checks for the remaining codes
    AST_LOWT_0: assert property (@(posedge clk) disable iff (srst)
        rd_data[LOWT_MSB:LOWT_LSB] == 2'h0
        |-> ctrl.lower_ratio == LOWT_RATIO_0)
        else $error("lower threshold code 0 wrong");
    AST_LOWT_2: assert property (@(posedge clk) disable iff (srst)
        rd_data[LOWT_MSB:LOWT_LSB] == 2'h2
        |-> ctrl.lower_ratio == LOWT_RATIO_2)
        else $error("lower threshold code 2 wrong");
    AST_LOWT_3: assert property (@(posedge clk) disable iff (srst)
        rd_data[LOWT_MSB:LOWT_LSB] == 2'h3
        |-> ctrl.lower_ratio == LOWT_RATIO_3)
        else $error("lower threshold code 3 wrong");
    AST_UPT_0: assert property (@(posedge clk) disable iff (srst)
        rd_data[UPT_MSB:UPT_LSB] == 2'h0
        |-> ctrl.upper_ratio == UPT_RATIO_0)
        else $error("upper threshold code 0 wrong");
    AST_UPT_2: assert property (@(posedge clk) disable iff (srst)
        rd_data[UPT_MSB:UPT_LSB] == 2'h2
        |-> ctrl.upper_ratio == UPT_RATIO_2)
        else $error("upper threshold code 2 wrong");
    AST_UPT_3: assert property (@(posedge clk) disable iff (srst)
        rd_data[UPT_MSB:UPT_LSB] == 2'h3
        |-> ctrl.upper_ratio == UPT_RATIO_3)
        else $error("upper threshold code 3 wrong");

    ////////////////////////////////////////////////////////////////////
    // timer reset is a single pulse per request; a host write ends
    // the watchdog fault unless a new expiry lands in the same cycle
    AST_TMR_PULSE: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> safety_timer_rst == $past(reg_rst_req))
        else $error("timer reset pulse wrong");
    AST_FAULT_CLEAR: assert property (@(posedge clk) disable iff (srst)
        wr_en && !wdog_expire |=> !wdog_fault)
        else $error("fault not cleared by host write");
endmodule : tpc_reg

// >>> tb/tpc_host.sv
/* host side: drives register writes, reset and watchdog pulses, range.
   assumes tpc_reg samples inputs on the rising edge of clk. */
`timescale 1ns/1ps
module tpc_host (
    input wire logic clk,
    output logic wr_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data,
    output logic reg_rst_req,
    output logic wdog_expire,
    output tpc_pkg::tpc_range_t temp_range
);
    import tpc_pkg::*;
    // idle values from time zero
    initial begin
        {wr_en, addr, wr_data, reg_rst_req, wdog_expire} = '0;
        temp_range = TPC_NORMAL;
    end
    // one-cycle byte write, changed only at falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
    // one-cycle watchdog expiry or register-reset request
    task automatic pulse(input logic wd);
        @(negedge clk);
        if (wd) wdog_expire = 1'b1;
        else reg_rst_req = 1'b1;
        @(negedge clk);
        {wdog_expire, reg_rst_req} = 2'h0;
    endtask : pulse
    // temperature range level, changed only at a falling edge
    task automatic set_range(input tpc_range_t r);
        @(negedge clk);
        temp_range = r;
    endtask : set_range
endmodule : tpc_host

// >>> tb/testbench.sv
/* self-checking bench for tpc_reg through the host model.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import tpc_pkg::*;
    logic clk, srst, wr_en, reg_rst_req, wdog_expire, st_rst, wdog_fault;
    logic [7:0] addr, wr_data, rd_data, d;
    tpc_range_t temp_range;
    tpc_ctrl_t ctrl, e;
    int n_errors = 0;
    int checked = 0;
    logic [6:0] pct [4] = '{PCT_0, PCT_1, PCT_2, PCT_3};
    logic [13:0] lo [4] = '{LOWT_RATIO_0, LOWT_RATIO_1, LOWT_RATIO_2,
        LOWT_RATIO_3};
    logic [13:0] up [4] = '{UPT_RATIO_0, UPT_RATIO_1, UPT_RATIO_2,
        UPT_RATIO_3};
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    tpc_reg dut (.clk(clk), .srst(srst), .wr_en(wr_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .reg_rst_req(reg_rst_req),
        .wdog_expire(wdog_expire), .temp_range(temp_range), .ctrl(ctrl),
        .safety_timer_rst(st_rst), .wdog_fault(wdog_fault));
    tpc_host host (.clk(clk), .wr_en(wr_en), .addr(addr),
        .wr_data(wr_data), .reg_rst_req(reg_rst_req),
        .wdog_expire(wdog_expire), .temp_range(temp_range));
    // counts, verdict and end of run
    task automatic end_sim;
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // settle range change through the one-cycle decode
    task automatic rng(input tpc_range_t r);
        host.set_range(r);
        repeat (2) @(negedge clk);
    endtask : rng
    // main sequence
    initial begin
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        `CHK(rd_data, TPC_RESET_VALUE)
        @(negedge clk);
        e = '{PCT_3, LOWT_RATIO_1, UPT_RATIO_1, 1'b0};
        `CHK(ctrl, e)
        // warm field is the inverse of the cool one, so a swap shows
        for (int r = 1; r < 3; r++) begin
            for (int c = 0; c < 4; c++) begin
                d = 8'(8'h55 * c) ^ 8'h30;
                host.wr(TPC_ADDR, d);
                `CHK(rd_data, d)
                rng(tpc_range_t'(r));
                e = '{pct[r == 1 ? c : c ^ 3], lo[c], up[c],
                    (c == 1 || c == 2)};
                `CHK(ctrl, e)
            end
        end
        host.wr(8'h0B, 8'h00);
        `CHK(rd_data, 8'hCF)
        host.wr(TPC_ADDR, 8'hA5);
        `CHK(rd_data, 8'hA5)
        host.pulse(1'b0);
        `CHK(rd_data, TPC_RESET_VALUE)
        `CHK(st_rst, 1'b1)
        @(negedge clk);
        `CHK(st_rst, 1'b0)
        rng(TPC_RANGE_COOL);
        `CHK(ctrl.charge_pct, PCT_1)
        host.wr(TPC_ADDR, 8'hA5);
        `CHK(rd_data, 8'hA5)
        host.pulse(1'b1);
        `CHK(rd_data, TPC_RESET_VALUE)
        `CHK(wdog_fault, 1'b1)
        rng(TPC_RANGE_WARM);
        `CHK(ctrl.charge_pct, PCT_3)
        host.wr(TPC_ADDR, 8'h00);
        `CHK(wdog_fault, 1'b0)
        rng(TPC_NORMAL);
        `CHK(ctrl.charge_pct, PCT_3)
        `CHK(ctrl.timer_double, 1'b0)
        // mid-run reset brings back the default and its decode
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        `CHK(rd_data, TPC_RESET_VALUE)
        e = '{PCT_3, LOWT_RATIO_1, UPT_RATIO_1, 1'b0};
        `CHK(ctrl, e)
        `CHK(st_rst, 1'b0)
        end_sim();
    end
endmodule : testbench
